// ==== pmd_access.sv ====
`timescale 1ns/10ps
`default_nettype none
module pmd_access (
  // Clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           arst_n,
  // Execution unit
  input  wire pmd_pkg::pmd_req_t              req,
  output var  logic                           ready_q,
  output var  pmd_pkg::pmd_rsp_t              rsp_q,
  // Program memory read port
  output var  logic                           prog_rd_q,
  output var  logic [pmd_pkg::PMD_PROG_AW-1:0] prog_addr_q,
  input  wire logic [pmd_pkg::PMD_PROG_DW-1:0] prog_data
);
  import pmd_pkg::*;

  pmd_state_t            state_q;
  pmd_state_t            state_d;
  pmd_dec_t              dec;
  pmd_dec_t              dec_q;
  logic                  take;
  logic                  ram_en;
  logic                  ram_we;
  logic [7:0]            ram_rdata_q;
  logic                  is_read_q;
  logic                  is_brw_q;

  // Bank/offset to general purpose or common index
  function automatic pmd_dec_t decode_banked(input logic [5:0] bank, input logic [6:0] ofs);
    pmd_dec_t d;
    logic [11:0] base;
    d = '0;
    base = 12'(bank) * PMD_GPR_SIZE;
    if (ofs >= PMD_COMMON_FIRST)
    begin
      d.ram_hit = 1'b1;
      d.ram_idx = PMD_RAM_AW'(ofs - PMD_COMMON_FIRST);
    end
    else if (ofs <= PMD_CORE_LAST)
    begin
      d.ext_hit = 1'b1;
    end
    else if (ofs < PMD_GPR_FIRST)
    begin
      d.ext_hit = (bank < PMD_UPPER_BANK);
    end
    else if (bank < PMD_GPR_BANKS)
    begin
      d.ram_hit = 1'b1;
      d.ram_idx = PMD_RAM_AW'(base + 12'(PMD_COMMON_SIZE) + 12'(ofs - PMD_GPR_FIRST));
    end
    return d;
  endfunction : decode_banked

  // Full pointer decode
  function automatic pmd_dec_t decode_ptr(input logic [15:0] ptr);
    pmd_dec_t    d;
    logic [11:0] lin;
    logic [11:0] lbank;
    logic [11:0] lofs;
    d = '0;
    lin = 12'(ptr - PMD_LIN_BASE);
    lbank = lin / PMD_GPR_SIZE;
    lofs = lin % PMD_GPR_SIZE;
    if (ptr[PMD_PROG_SEL_BIT])
    begin
      d.prog = 1'b1;
      d.prog_addr = ptr[PMD_PROG_AW-1:0];
    end
    else if (ptr <= PMD_TRAD_LAST)
    begin
      d = decode_banked({1'b0, ptr[11:7]}, ptr[6:0]);
    end
    else if (ptr >= PMD_LIN_BASE && ptr <= PMD_LIN_LAST)
    begin
      // Linear window skips core, gap and common bytes
      d = decode_banked(lbank[5:0], 7'(PMD_GPR_FIRST + 7'(lofs)));
    end
    return d;
  endfunction : decode_ptr

  assign dec  = decode_ptr(req.ptr);
  assign take = req.valid && (state_q == PMD_ST_IDLE);

  always_comb
  begin
    ram_en = 1'b0;
    ram_we = 1'b0;
    if (take && (req.op == PMD_OP_READ || req.op == PMD_OP_WRITE) && dec.ram_hit)
    begin
      ram_en = 1'b1;
      ram_we = (req.op == PMD_OP_WRITE);
    end
  end

  pmd_ram u_ram (
    .clk_sys (clk_sys),
    .en      (ram_en),
    .we      (ram_we),
    .addr    (dec.ram_idx),
    .wdata   (req.wdata),
    .rdata_q (ram_rdata_q)
  );

  // Sequencing
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PMD_ST_IDLE:
      begin
        if (take)
        begin
          if (req.op == PMD_OP_READ && dec.prog)
          begin
            state_d = PMD_ST_PADDR;
          end
          else
          begin
            state_d = PMD_ST_DATA;
          end
        end
      end
      PMD_ST_DATA:
      begin
        state_d = PMD_ST_IDLE;
      end
      PMD_ST_PADDR:
      begin
        state_d = PMD_ST_PDATA;
      end
      PMD_ST_PDATA:
      begin
        state_d = PMD_ST_IDLE;
      end
      default:
      begin
        state_d = PMD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= PMD_ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ready_q <= 1'b1;
    end
    else
    begin
      ready_q <= (state_d == PMD_ST_IDLE);
    end
  end

  // Captured decode for the completion cycle
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dec_q     <= '0;
      is_read_q <= 1'b0;
      is_brw_q  <= 1'b0;
    end
    else if (take)
    begin
      dec_q     <= dec;
      is_read_q <= (req.op == PMD_OP_READ);
      is_brw_q  <= (req.op == PMD_OP_BRW);
    end
  end

  // Program memory read strobe; write requests never reach it
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prog_rd_q   <= 1'b0;
      prog_addr_q <= '0;
    end
    else
    begin
      prog_rd_q <= take && (req.op == PMD_OP_READ) && dec.prog;
      if (take && dec.prog)
      begin
        prog_addr_q <= dec.prog_addr;
      end
    end
  end

  // Answer
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rsp_q <= '0;
    end
    else
    begin
      rsp_q.done     <= 1'b0;
      rsp_q.acc_load <= 1'b0;
      rsp_q.pc_load  <= 1'b0;
      if (take)
      begin
        rsp_q.ext_hit <= 1'b0;
        case (req.op)
          PMD_OP_BRW:
          begin
            rsp_q.pc_target <= req.pc + PMD_PROG_AW'(1) + PMD_PROG_AW'(req.acc);
          end
          PMD_OP_RETURN_WITH_LITERAL:
          begin
            rsp_q.rdata <= req.literal;
          end
          default:
          begin
            rsp_q.rdata <= PMD_ZERO_BYTE;
          end
        endcase
      end
      case (state_q)
        PMD_ST_DATA:
        begin
          rsp_q.done    <= 1'b1;
          rsp_q.ext_hit <= dec_q.ext_hit;
          if (is_read_q)
          begin
            rsp_q.acc_load <= 1'b1;
            rsp_q.rdata    <= dec_q.ram_hit ? ram_rdata_q : PMD_ZERO_BYTE;
          end
          rsp_q.pc_load <= is_brw_q;
        end
        PMD_ST_PDATA:
        begin
          rsp_q.done     <= 1'b1;
          rsp_q.acc_load <= 1'b1;
          rsp_q.rdata    <= prog_data[7:0];
        end
        default:
        begin
        end
      endcase
    end
  end

endmodule : pmd_access
`default_nettype wire

// ==== pmd_pkg.sv ====
`default_nettype none
package pmd_pkg;

  // Address space
  localparam logic [15:0] PMD_PROG_SEL_MASK   = 16'h8000;
  localparam int          PMD_PROG_SEL_BIT    = 15;
  localparam int          PMD_PROG_AW         = 15;
  localparam int          PMD_PROG_DW         = 14;
  localparam logic [15:0] PMD_LIN_BASE        = 16'h2000;
  localparam logic [15:0] PMD_LIN_LAST        = 16'h2fef;
  localparam logic [15:0] PMD_TRAD_LAST       = 16'h0fff;
  localparam logic [6:0]  PMD_CORE_LAST       = 7'h0b;
  localparam logic [6:0]  PMD_GPR_FIRST       = 7'h20;
  localparam logic [6:0]  PMD_GPR_LAST        = 7'h6f;
  localparam logic [6:0]  PMD_COMMON_FIRST    = 7'h70;
  localparam logic [11:0] PMD_GPR_SIZE        = 12'h050;
  localparam logic [5:0]  PMD_UPPER_BANK      = 6'h18;
  localparam logic [5:0]  PMD_GPR_BANKS       = 6'h19;
  localparam int          PMD_COMMON_SIZE     = 16;

  // Data memory
  localparam int          PMD_RAM_AW          = 11;
  localparam int          PMD_RAM_DEPTH       = 2016;
  localparam logic [7:0]  PMD_ZERO_BYTE       = 8'h00;

  // Operations from the execution unit
  typedef enum logic [2:0] {
    PMD_OP_READ  = 3'h0,
    PMD_OP_WRITE = 3'h1,
    PMD_OP_BRW   = 3'h2,
    PMD_OP_RETURN_WITH_LITERAL = 3'h3
  } pmd_op_t;

  typedef enum logic [3:0] {
    PMD_ST_IDLE  = 4'b0001,
    PMD_ST_DATA  = 4'b0010,
    PMD_ST_PADDR = 4'b0100,
    PMD_ST_PDATA = 4'b1000
  } pmd_state_t;

  typedef struct packed {
    logic                   valid;
    pmd_op_t                op;
    logic [15:0]            ptr;
    logic [7:0]             wdata;
    logic [7:0]             acc;
    logic [PMD_PROG_AW-1:0] pc;
    logic [7:0]             literal;
  } pmd_req_t;

  typedef struct packed {
    logic                   done;
    logic [7:0]             rdata;
    logic                   acc_load;
    logic                   ext_hit;
    logic                   pc_load;
    logic [PMD_PROG_AW-1:0] pc_target;
  } pmd_rsp_t;

  typedef struct packed {
    logic                   prog;
    logic [PMD_PROG_AW-1:0] prog_addr;
    logic                   ram_hit;
    logic [PMD_RAM_AW-1:0]  ram_idx;
    logic                   ext_hit;
  } pmd_dec_t;

endpackage : pmd_pkg
`default_nettype wire

// ==== pmd_ram.sv ====
`timescale 1ns/10ps
`default_nettype none
module pmd_ram (
  // Clock
  input  wire logic                          clk_sys,
  // Port
  input  wire logic                          en,
  input  wire logic                          we,
  input  wire logic [pmd_pkg::PMD_RAM_AW-1:0] addr,
  input  wire logic [7:0]                    wdata,
  output var  logic [7:0]                    rdata_q
);
  import pmd_pkg::*;

  logic [7:0] mem [0:PMD_RAM_DEPTH-1];

  always_ff @(posedge clk_sys)
  begin
    if (en && we)
    begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (en)
    begin
      rdata_q <= mem[addr];
    end
  end

endmodule : pmd_ram
`default_nettype wire

// ==== pmd_access_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module pmd_access_asserts (
  // Clock and reset
  input wire logic                            clk_sys,
  input wire logic                            arst_n,
  // Execution unit
  input wire pmd_pkg::pmd_req_t               req,
  input wire logic                            ready_q,
  input wire pmd_pkg::pmd_rsp_t               rsp_q,
  // Program memory
  input wire logic                            prog_rd_q,
  input wire logic [pmd_pkg::PMD_PROG_AW-1:0] prog_addr_q,
  input wire logic [pmd_pkg::PMD_PROG_DW-1:0] prog_data
);
  import pmd_pkg::*;
  logic       tk;
  logic [7:0] pd_q;
  assign tk = req.valid && ready_q;
  always_ff @(posedge clk_sys) pd_q <= prog_data[7:0];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence prog_take_s; tk && req.op == PMD_OP_READ && req.ptr[15]; endsequence
  sequence prog_fetch_s; prog_rd_q && !rsp_q.done ##1 !rsp_q.done ##1 rsp_q.done && rsp_q.acc_load; endsequence
  sequence brw_take_s; tk && req.op == PMD_OP_BRW; endsequence
  sequence brw_done_s; !rsp_q.pc_load ##1 rsp_q.done && rsp_q.pc_load; endsequence
  data_no_fetch_a: assert property (tk && !req.ptr[15] |=> !prog_rd_q) else $error("fetch");
  extra_cycle_a: assert property (prog_take_s |=> prog_fetch_s) else $error("prog");
  data_latency_a: assert property (
    tk && !(req.op == PMD_OP_READ && req.ptr[15]) |=> !rsp_q.done ##1 rsp_q.done) else $error("lat");
  low_byte_a: assert property (prog_rd_q |-> ##2 rsp_q.rdata == pd_q) else $error("byte");
  prog_addr_a: assert property (prog_take_s |=> prog_addr_q == $past(req.ptr[14:0])) else $error("addr");
  prog_write_a: assert property (
    tk && req.op == PMD_OP_WRITE && req.ptr[15] |=> !prog_rd_q [*2]) else $error("wr");
  brw_target_a: assert property (
    brw_take_s |=> rsp_q.pc_target == 15'($past(req.pc) + 15'($past(req.acc)) + 15'h1)) else $error("brw");
  brw_load_a: assert property (brw_take_s |=> brw_done_s) else $error("pc load");
  return_with_literal_a: assert property (
    tk && req.op == PMD_OP_RETURN_WITH_LITERAL |-> ##2 rsp_q.done && !rsp_q.acc_load && rsp_q.rdata == $past(req.literal, 2))
    else $error("lit");
  zero_read_a: assert property (
    tk && req.op == PMD_OP_READ && req.ptr[15:12] == 4'h1 |-> ##2 rsp_q.rdata == 8'h00 && !rsp_q.ext_hit)
    else $error("zero");
  busy_ready_a: assert property (tk |=> !ready_q) else $error("ready");
endmodule : pmd_access_asserts
bind pmd_access pmd_access_asserts u_chk (.clk_sys(clk_sys), .arst_n(arst_n), .req(req), .ready_q(ready_q),
  .rsp_q(rsp_q), .prog_rd_q(prog_rd_q), .prog_addr_q(prog_addr_q), .prog_data(prog_data));
`default_nettype wire

// ==== program_memory_data_read_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module program_memory_data_read_bench;
  import pmd_pkg::*;
  logic        clk_sys;
  logic        arst_n;
  pmd_req_t    req;
  logic        ready_q;
  pmd_rsp_t    rsp_q;
  logic        prog_rd_q;
  logic [14:0] prog_addr_q;
  logic [13:0] prog_data;
  logic        rd_seen;
  int          err_count;
  int          num_checks;
  int          cyc;
  int          mem[int];
  int          pl[$] = '{'h0075, 'h0f75, 'h204f, 'h2050, 'h00a0, 'h00ef, 'h80a0, 'h0c0c, 'h0ca0,
                         'h0c6f, 'h0c20, 'h1000, 'h2fe0, 'h0005, 'h8123, 'hffff};

  pmd_access dut (.clk_sys(clk_sys), .arst_n(arst_n), .req(req), .ready_q(ready_q), .rsp_q(rsp_q),
    .prog_rd_q(prog_rd_q), .prog_addr_q(prog_addr_q), .prog_data(prog_data));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  function automatic logic [13:0] pf(input logic [14:0] a);
    return 14'(a * 15'h25) ^ 14'h2a5b;
  endfunction : pf

  // Model address map: -1 reads zero, -2 outside register, else byte key
  function automatic int key(input int p);
    int b;
    int o;
    if (p >= 'h2000 && p < 'h2ff0)
    begin
      b = (p - 'h2000) / 80;
      o = 'h20 + (p - 'h2000) % 80;
    end
    else if (p >= 'h1000) return -1;
    else
    begin
      b = p / 128;
      o = p % 128;
    end
    if (o >= 'h70) return o;
    if (o < 'h0c || (o < 'h20 && b < 24)) return -2;
    if (o < 'h20 || b > 24) return -1;
    return b * 128 + o;
  endfunction : key

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // Synchronous program memory: word stands only in the cycle after the strobe
  always @(negedge clk_sys)
  begin
    cyc++;
    prog_data <= rd_seen ? pf(prog_addr_q) : ~prog_data;
    rd_seen   <= prog_rd_q;
    if (cyc > 5000)
    begin
      err_count++;
      report_and_stop;
    end
  end

  task automatic run(input pmd_op_t op, input int p, input logic [7:0] d);
    int          n;
    int          k;
    logic [14:0] pc;
    logic [7:0]  lit;
    pc = 15'($urandom);
    lit = 8'($urandom);
    k = key(p);
    req = '{1'b1, op, 16'(p), d, d, pc, lit};
    n = 0;
    @(posedge clk_sys);
    do
    begin
      @(negedge clk_sys);
      // Valid drops once, so the next request may raise it at done
      if (n == 0)
      begin
        req.valid = 1'b0;
        chk("ready busy", ready_q, 1'b0);
      end
      n++;
    end while (rsp_q.done !== 1'b1 && n < 6);
    chk("latency", n, (op == PMD_OP_READ && p[15]) ? 3 : 2);
    chk("ready idle", ready_q, 1'b1);
    chk("acc load", rsp_q.acc_load, op == PMD_OP_READ);
    chk("pc load", rsp_q.pc_load, op == PMD_OP_BRW);
    if (op == PMD_OP_WRITE && k >= 0) mem[k] = d;
    else if (op == PMD_OP_BRW) chk("target", rsp_q.pc_target, 15'(pc + 15'(d) + 15'h1));
    else if (op == PMD_OP_RETURN_WITH_LITERAL) chk("literal", rsp_q.rdata, lit);
    else if (op == PMD_OP_READ && p[15]) chk("prog", rsp_q.rdata, 8'(pf(15'(p))));
    else if (op == PMD_OP_READ && (k < 0 || mem.exists(k)))
      chk("data", rsp_q.rdata, k < 0 ? 0 : mem[k]);
    if (op == PMD_OP_READ && !p[15]) chk("ext", rsp_q.ext_hit, k == -2);
  endtask : run

  initial
  begin
    int p;
    err_count = 0;
    num_checks = 0;
    cyc = 0;
    req = '0;
    prog_data = '0;
    rd_seen = 1'b0;
    arst_n = 1'b0;
    void'($urandom(32'hd0f09a70));
    repeat (20) @(negedge clk_sys);
    arst_n = 1'b1;
    @(negedge clk_sys);
    foreach (pl[i]) run(PMD_OP_WRITE, pl[i], 8'($urandom));
    foreach (pl[i]) run(PMD_OP_READ, pl[i], 8'h00);
    run(PMD_OP_BRW, 0, 8'hff);
    run(PMD_OP_RETURN_WITH_LITERAL, 0, 8'h00);
    repeat (300)
    begin
      p = $urandom_range(1) ? pl[$urandom_range(pl.size() - 1)] : $urandom_range('h2fff);
      run(pmd_op_t'($urandom_range(3)), p, 8'($urandom));
    end
    report_and_stop;
  end
endmodule : program_memory_data_read_bench
`default_nettype wire
